// file: logic/adc_status_and_cal_regs.sv
// read-back status word and calibration register access of the converter
// assumes the serial frame logic delivers control words, reads and
// calibration writes as one-cycle strobes on the master clock
//
// Contract
// - read-only 16-bit status word, selected by read-select bits 11
// - every status bit is zero after power-up
// - status bit 15 always reads zero
// - status bit 14 is one while converting or calibrating
// - bits 13..10 echo input-mode flag and channel select
// - bits 9..8 echo the power-management setting
// - bits 7..6 read as ones, naming the status word
// - bit 5 shows interface mode, cleared after every read cycle unless a control write lands in its answer cycle
// - bit 3 shows self or system calibration mode
// - bit 0 shows calibration running, bits 2..1 the cal selection
// - ten calibration registers, all readable and writable
// - calibration engine updates those registers itself
// - cal-select decode: all ten, gain+offset, offset, gain
// - pointer resets on control write and on sequence end
// - pointer starts at gain, offset only for offset-alone select
// - pointer advances after each access in multi-register sequences
// - abandoned sequence: next control write resets pointer
// - calibration reads carry two leading zero bits
// - offset and gain are 16 bits: two zeros, 14 data
`timescale 1ns/10ps
`default_nettype none
`include "adc_regs_defines.svh"

module adc_status_and_cal_regs
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control register write
  input wire logic ctrlWrite,
  input wire logic [`WORD_BITS-1:0] ctrlWord,
  // read request and answer
  input wire logic readReq,
  output logic readReady,
  output logic readValid,
  output logic [`WORD_BITS-1:0] readWord,
  // calibration data write from the host
  input wire logic calWrite,
  input wire logic [`WORD_BITS-1:0] calWriteData,
  // converter and calibration engine
  input wire logic convBusy,
  input wire logic calRunning,
  input wire logic [11:0] convResult,
  input wire logic calEngWrite,
  input wire logic [3:0] calEngIndex,
  input wire logic [`CAL_DATA_BITS-1:0] calEngData,
  // state view
  output logic [`WORD_BITS-1:0] statusWord,
  output logic [3:0] calPointer
);

  adc_regs_pkg::rd_state_t stateQ;
  adc_regs_pkg::rd_state_t stateD;
  adc_regs_pkg::read_sel_t kindQ;
  logic [`WORD_BITS-1:0] ctrlQ;
  logic modeQ;
  logic [`WORD_BITS-1:0] statusQ;
  logic [`WORD_BITS-1:0] readWordQ;

  wire logic [`WORD_BITS-1:0] statusD;
  wire logic [`WORD_BITS-1:0] answerD;
  wire logic [`WORD_BITS-1:0] calData;
  wire logic [3:0] ptr;
  wire adc_regs_pkg::read_sel_t readSel;
  wire adc_regs_pkg::cal_sel_t calSelQ;
  wire adc_regs_pkg::cal_sel_t calSelNow;
  wire logic takeRead;
  wire logic answerCycle;
  wire logic hostWriteTaken;
  wire logic calReadDone;
  wire logic storeWe;
  wire logic [3:0] storeAddr;
  wire logic [`CAL_DATA_BITS-1:0] storeData;
  wire logic modeD;

  // decode of the latched control word
  assign readSel = adc_regs_pkg::read_sel_t'(ctrlQ[`POS_RS_HI:`POS_RS_LO]);
  assign calSelQ = adc_regs_pkg::cal_sel_t'(ctrlQ[`POS_CSEL_HI:`POS_CSEL_LO]);
  // a control write steers the pointer in the same cycle it lands
  assign calSelNow = ctrlWrite ? adc_regs_pkg::cal_sel_t'(ctrlWord[`POS_CSEL_HI:`POS_CSEL_LO]) : calSelQ;

  // read cycle handshake
  assign readReady = (stateQ == adc_regs_pkg::RD_IDLE);
  assign takeRead = readReq && readReady;
  assign answerCycle = (stateQ == adc_regs_pkg::RD_ANSWER);
  assign readValid = answerCycle;
  assign calReadDone = answerCycle && (kindQ == adc_regs_pkg::SEL_CAL);

  // engine has the store to itself while it writes; a clashing host write is dropped
  assign hostWriteTaken = calWrite && !calEngWrite;
  assign storeWe = calEngWrite || hostWriteTaken;
  assign storeAddr = calEngWrite ? calEngIndex : ptr;
  assign storeData = calEngWrite ? calEngData : calWriteData[`CAL_DATA_BITS-1:0];

  // mode bit: a control write in the completing cycle keeps its value
  assign modeD = ctrlWrite ? ctrlWord[`POS_MODE] : (answerCycle ? 1'b0 : modeQ);

  assign statusD = {1'b0,
                    convBusy || calRunning,
                    ctrlQ[`POS_SINGLE_ENDED:`POS_CH_LO],
                    ctrlQ[`POS_PM_HI:`POS_PM_LO],
                    2'b11,
                    modeQ,
                    1'b0,
                    ctrlQ[`POS_CAL_TYPE],
                    ctrlQ[`POS_CSEL_HI:`POS_CSEL_LO],
                    calRunning};

  // test register reads as zero
  assign answerD = (kindQ == adc_regs_pkg::SEL_STATUS) ? statusQ :
                   (kindQ == adc_regs_pkg::SEL_CAL) ? calData :
                   (kindQ == adc_regs_pkg::SEL_RESULT) ? {4'h0, convResult} :
                   16'h0000;

  always_comb
  begin
    stateD = stateQ;
    unique case (stateQ)
      adc_regs_pkg::RD_IDLE:
        if (takeRead)
          stateD = adc_regs_pkg::RD_FETCH;
      adc_regs_pkg::RD_FETCH:
        stateD = adc_regs_pkg::RD_ANSWER;
      adc_regs_pkg::RD_ANSWER:
        stateD = adc_regs_pkg::RD_IDLE;
      default:
        stateD = adc_regs_pkg::RD_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      stateQ <= adc_regs_pkg::RD_IDLE;
      kindQ <= adc_regs_pkg::SEL_RESULT;
    end
    else
    begin
      stateQ <= stateD;
      if (takeRead)
        kindQ <= readSel;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ctrlQ <= 16'h0000;
      modeQ <= 1'b0;
    end
    else
    begin
      if (ctrlWrite)
        ctrlQ <= ctrlWord;
      modeQ <= modeD;
    end
  end

  // status is a register so a read sees one coherent snapshot
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      statusQ <= `STATUS_RESET;
    else
      statusQ <= statusD;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      readWordQ <= 16'h0000;
    else if (stateQ == adc_regs_pkg::RD_FETCH)
      readWordQ <= answerD;
  end

  cal_pointer u_pointer
  (
    .clock(clock),
    .rst_n(rst_n),
    .load(ctrlWrite),
    .step(calReadDone || hostWriteTaken),
    .calSel(calSelNow),
    .ptr(ptr)
  );

  // store reads the pointer every cycle; the fetch state covers its latency
  cal_store u_store
  (
    .clock(clock),
    .rst_n(rst_n),
    .wrEn(storeWe),
    .wrAddr(storeAddr),
    .wrData(storeData),
    .rdAddr(ptr),
    .rdData(calData)
  );

  assign readWord = readWordQ;
  assign statusWord = statusQ;
  assign calPointer = ptr;

  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_status_reset_zero: assert property (@(posedge clock) disable iff (1'b0) !rst_n |=> statusWord == `STATUS_RESET)
    else $error("status word not cleared by reset");

  a_status_msb_zero: assert property (statusWord[`POS_ZERO] == 1'b0)
    else $error("status msb not zero");

  a_status_busy_bit: assert property ($past(rst_n) |-> statusWord[`POS_BUSY] == $past(convBusy || calRunning))
    else $error("busy bit does not follow converter and calibration");

  a_status_ctrl_echo: assert property (ctrlWrite |-> ##2 statusWord[13:8] == $past(ctrlWord[13:8], 2))
    else $error("channel or power bits not echoed");

  a_status_power_bits: assert property (ctrlWrite ##1 !ctrlWrite |=> statusWord[9:8] == $past(ctrlWord[9:8], 2))
    else $error("power management bits not echoed");

  a_status_ident_bits: assert property ($past(rst_n) |-> statusWord[`POS_RS_HI:`POS_RS_LO] == 2'b11)
    else $error("status identifier bits not ones");

  a_mode_bit_clear: assert property (readValid && !ctrlWrite |=> ##1 statusWord[`POS_MODE] == 1'b0)
    else $error("mode bit not cleared after read cycle");

  a_status_cal_fields: assert property (ctrlWrite |-> ##2 statusWord[3:1] == $past(ctrlWord[3:1], 2))
    else $error("calibration mode or select not echoed");

  a_status_cal_run: assert property ($past(rst_n) |-> statusWord[`POS_CAL_START] == $past(calRunning))
    else $error("calibration running bit wrong");

  a_cal_read_zeros: assert property (calReadDone |-> readWord[15:14] == 2'b00)
    else $error("calibration read lacks leading zeros");

  a_ptr_offset_load: assert property (ctrlWrite && ctrlWord[2:1] == 2'b10 |=> calPointer == `IDX_OFFSET)
    else $error("offset-only selection does not start at offset");

  a_ptr_gain_load: assert property (ctrlWrite && ctrlWord[2:1] != 2'b10 |=> calPointer == `IDX_GAIN)
    else $error("pointer not reset to gain");

  a_ptr_advance: assert property (hostWriteTaken && !ctrlWrite && !calReadDone
                                  && calSelQ == adc_regs_pkg::CAL_ALL && calPointer != `IDX_DAC_LAST
                                  |=> calPointer == $past(calPointer) + 4'h1)
    else $error("pointer did not advance");

  a_ptr_wrap: assert property ((hostWriteTaken || calReadDone) && !ctrlWrite
                               && calSelQ == adc_regs_pkg::CAL_GAIN_OFFSET && calPointer == `IDX_OFFSET
                               |=> calPointer == `IDX_GAIN)
    else $error("pointer did not return to start");

  a_read_latency: assert property (takeRead |-> !readValid ##`READ_LATENCY readValid)
    else $error("read answer not on time");

  a_mode_bit_echo: assert property (ctrlWrite |-> ##2 statusWord[`POS_MODE] == $past(ctrlWord[`POS_MODE], 2))
    else $error("mode bit not echoed from control word");

  a_cal_run_busy: assert property (statusWord[`POS_CAL_START] |-> statusWord[`POS_BUSY])
    else $error("calibration running but busy bit low");

  a_engine_priority: assert property (calEngWrite && calWrite && !ctrlWrite && !calReadDone
                                      |=> calPointer == $past(calPointer))
    else $error("pointer moved on a dropped host write");

  a_ptr_gain_hold: assert property (calSelQ == adc_regs_pkg::CAL_GAIN && !ctrlWrite
                                    |=> calPointer == `IDX_GAIN)
    else $error("gain-only selection left the gain register");

  a_ptr_offset_hold: assert property (calSelQ == adc_regs_pkg::CAL_OFFSET && !ctrlWrite
                                      |=> calPointer == `IDX_OFFSET)
    else $error("offset-only selection left the offset register");

  a_ptr_in_range: assert property (calPointer <= `IDX_DAC_LAST)
    else $error("pointer beyond last calibration register");

  a_ready_after_answer: assert property (readValid |=> readReady && !readValid)
    else $error("read cycle did not return to idle");

  a_read_word_holds: assert property ($past(rst_n) && !readValid |-> $stable(readWord))
    else $error("read word changed outside an answer");

  a_status_answer: assert property (takeRead && readSel == adc_regs_pkg::SEL_STATUS
                                    |-> ##2 readWord == $past(statusWord))
    else $error("status read returned wrong word");

  a_result_answer: assert property (takeRead && readSel == adc_regs_pkg::SEL_RESULT
                                    |-> ##2 readWord == {4'h0, $past(convResult)})
    else $error("result read returned wrong word");

  a_test_read_zero: assert property (takeRead && readSel == adc_regs_pkg::SEL_TEST |-> ##2 readWord == 16'h0000)
    else $error("test register read not zero");

  c_status_read: cover property (takeRead && readSel == adc_regs_pkg::SEL_STATUS ##2 readValid);
  c_cal_read: cover property (calReadDone && calSelQ == adc_regs_pkg::CAL_ALL);
  c_full_wrap: cover property (hostWriteTaken && calPointer == `IDX_DAC_LAST ##1 calPointer == `IDX_GAIN);
  c_engine_write: cover property (calEngWrite && calWrite);
  c_offset_only: cover property (ctrlWrite && ctrlWord[2:1] == 2'b10);

endmodule
`default_nettype wire

// file: logic/adc_regs_defines.svh
// offsets, field positions, reset values and sizes of the read-back status
// word and the calibration store; definitions only
`ifndef ADC_REGS_DEFINES_SVH
`define ADC_REGS_DEFINES_SVH

`define WORD_BITS 16
`define CAL_DATA_BITS 14
`define CAL_COUNT 10
`define STATUS_RESET 16'h0000

// status and control word share these positions
`define POS_ZERO 15
`define POS_BUSY 14
`define POS_SINGLE_ENDED 13
`define POS_CH_HI 12
`define POS_CH_LO 10
`define POS_PM_HI 9
`define POS_PM_LO 8
`define POS_RS_HI 7
`define POS_RS_LO 6
`define POS_MODE 5
`define POS_SPARE 4
`define POS_CAL_TYPE 3
`define POS_CSEL_HI 2
`define POS_CSEL_LO 1
`define POS_CAL_START 0

// calibration store entries in access order
`define IDX_GAIN 4'h0
`define IDX_OFFSET 4'h1
`define IDX_DAC_LAST 4'h9
`define IDX_NONE 4'hF

// cycles from an accepted read request to its answer
`define READ_LATENCY 2

`endif

// file: logic/adc_regs_pkg.sv
// types shared by the status and calibration register logic
// assumes nothing outside; no imports
package adc_regs_pkg;

  typedef enum logic [1:0]
  {
    RD_IDLE = 2'b00,
    RD_FETCH = 2'b01,
    RD_ANSWER = 2'b11
  } rd_state_t;

  typedef enum logic [1:0]
  {
    SEL_RESULT = 2'b00,
    SEL_TEST = 2'b01,
    SEL_CAL = 2'b10,
    SEL_STATUS = 2'b11
  } read_sel_t;

  typedef enum logic [1:0]
  {
    CAL_ALL = 2'b00,
    CAL_GAIN_OFFSET = 2'b01,
    CAL_OFFSET = 2'b10,
    CAL_GAIN = 2'b11
  } cal_sel_t;

endpackage

// file: logic/cal_store.sv
// ten 14-bit calibration words, one write port, registered read
// assumes one writer per cycle; index order gain, offset, dac 1..8
`timescale 1ns/10ps
`default_nettype none
`include "adc_regs_defines.svh"

module cal_store
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // write port
  input wire logic wrEn,
  input wire logic [3:0] wrAddr,
  input wire logic [`CAL_DATA_BITS-1:0] wrData,
  // read port
  input wire logic [3:0] rdAddr,
  output logic [`WORD_BITS-1:0] rdData
);

  logic [`CAL_DATA_BITS-1:0] entry [`CAL_COUNT];
  logic [`WORD_BITS-1:0] rdDataQ;

  genvar i;
  generate
    for (i = 0; i < `CAL_COUNT; i++)
    begin : g_entry
      always_ff @(posedge clock)
      begin
        if (!rst_n)
          entry[i] <= '0;
        else if (wrEn && wrAddr == 4'(i))
          entry[i] <= wrData;
      end
    end
  endgenerate

  // two leading zeros are never stored, only prepended
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      rdDataQ <= '0;
    else if (rdAddr < 4'(`CAL_COUNT))
      rdDataQ <= {2'b00, entry[rdAddr]};
    else
      rdDataQ <= '0;
  end

  assign rdData = rdDataQ;

endmodule
`default_nettype wire

// file: logic/cal_pointer.sv
// auto-incrementing pointer into the calibration store
// load and step come from the same clock; load wins over step
`timescale 1ns/10ps
`default_nettype none
`include "adc_regs_defines.svh"

module cal_pointer
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic step,
  input wire adc_regs_pkg::cal_sel_t calSel,
  // pointer
  output logic [3:0] ptr
);

  logic [3:0] ptrQ;
  logic [3:0] ptrD;
  wire logic [3:0] startIdx;
  wire logic [3:0] lastIdx;
  wire logic [3:0] nextIdx;

  assign startIdx = (calSel == adc_regs_pkg::CAL_OFFSET) ? `IDX_OFFSET : `IDX_GAIN;
  assign lastIdx = (calSel == adc_regs_pkg::CAL_ALL) ? `IDX_DAC_LAST :
                   (calSel == adc_regs_pkg::CAL_GAIN_OFFSET) ? `IDX_OFFSET :
                   startIdx;
  // single-register selections simply stay put
  assign nextIdx = (ptrQ == lastIdx) ? startIdx : ptrQ + 4'h1;
  assign ptrD = load ? startIdx : (step ? nextIdx : ptrQ);

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      ptrQ <= `IDX_GAIN;
    else
      ptrQ <= ptrD;
  end

  assign ptr = ptrQ;

endmodule
`default_nettype wire

// file: testbench/host_model.sv
// host side of the register access: control writes, calibration writes, reads
// assumes the block samples on the rising edge; requests change on the falling
`timescale 1ns/10ps
`default_nettype none
`include "adc_regs_defines.svh"

module host_model
(
  // clock
  input wire logic clock,
  // answers from the block
  input wire logic readReady,
  input wire logic readValid,
  input wire logic [`WORD_BITS-1:0] readWord,
  // requests to the block
  output var logic ctrlWrite,
  output var logic [`WORD_BITS-1:0] ctrlWord,
  output var logic readReq,
  output var logic calWrite,
  output var logic [`WORD_BITS-1:0] calWriteData,
  // a bounded wait ran out
  output var logic hung
);
  initial
  begin
    ctrlWrite = 1'b0;
    ctrlWord = 16'h0000;
    readReq = 1'b0;
    calWrite = 1'b0;
    calWriteData = 16'h0000;
    hung = 1'b0;
  end

  // every calibration sequence opens with one of these
  task automatic writeCtrl(input logic [`WORD_BITS-1:0] wd);
    @(negedge clock);
    ctrlWrite = 1'b1;
    ctrlWord = wd;
    @(negedge clock);
    ctrlWrite = 1'b0;
    // stale word not left standing once the strobe is gone
    ctrlWord = ~wd;
  endtask

  task automatic writeCal(input logic [`WORD_BITS-1:0] d);
    @(negedge clock);
    calWrite = 1'b1;
    calWriteData = d;
    @(negedge clock);
    calWrite = 1'b0;
    calWriteData = ~d;
  endtask

  // request held through the taking edge; answer awaited under a bound
  task automatic readOne(output logic [`WORD_BITS-1:0] rd);
    int i;
    @(negedge clock);
    for (i = 0; i < 8 && readReady !== 1'b1; i++)
      @(negedge clock);
    if (readReady !== 1'b1)
      hung = 1'b1;
    readReq = 1'b1;
    @(negedge clock);
    readReq = 1'b0;
    for (i = 0; i < 4 && readValid !== 1'b1; i++)
      @(negedge clock);
    if (readValid !== 1'b1)
      hung = 1'b1;
    rd = readWord;
  endtask
endmodule
`default_nettype wire

// file: testbench/adc_status_and_cal_regs_tb.sv
// self-checking bench for the status word and calibration register access
// assumes host_model drives the host requests; bench drives the engine side
`timescale 1ns/10ps
`default_nettype none
`include "adc_regs_defines.svh"

module adc_status_and_cal_regs_tb;
  logic clock;
  logic rst_n;
  logic convBusy;
  logic calRunning;
  logic [11:0] convResult;
  logic calEngWrite;
  logic [3:0] calEngIndex;
  logic [13:0] calEngData;
  wire logic ctrlWrite;
  wire logic [15:0] ctrlWord;
  wire logic readReq;
  wire logic readReady;
  wire logic readValid;
  wire logic [15:0] readWord;
  wire logic calWrite;
  wire logic [15:0] calWriteData;
  wire logic [15:0] statusWord;
  wire logic [3:0] calPointer;
  wire logic hung;
  int n_mismatch;
  int checks_done;
  logic [15:0] w;
  logic [15:0] calVal [10];
  logic [15:0] stWord [3] = '{16'hFFFF, 16'h6AE9, 16'h95D2};
  localparam logic [2:0] BUSY_SET = 3'b010;
  localparam logic [2:0] RUN_SET = 3'b100;

  adc_status_and_cal_regs i_adc_status_and_cal_regs
  (
    .clock(clock), .rst_n(rst_n), .ctrlWrite(ctrlWrite), .ctrlWord(ctrlWord),
    .readReq(readReq), .readReady(readReady), .readValid(readValid), .readWord(readWord),
    .calWrite(calWrite), .calWriteData(calWriteData), .convBusy(convBusy), .calRunning(calRunning),
    .convResult(convResult), .calEngWrite(calEngWrite), .calEngIndex(calEngIndex),
    .calEngData(calEngData), .statusWord(statusWord), .calPointer(calPointer)
  );

  host_model i_host_model
  (
    .clock(clock), .readReady(readReady), .readValid(readValid), .readWord(readWord),
    .ctrlWrite(ctrlWrite), .ctrlWord(ctrlWord), .readReq(readReq), .calWrite(calWrite),
    .calWriteData(calWriteData), .hung(hung)
  );

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  function automatic logic [15:0] expStatus(input logic [15:0] c, input logic b, input logic r, input logic m);
    return {1'b0, b | r, c[13:8], 2'b11, m, 1'b0, c[3], c[2:1], r};
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one idle cycle first, so a late pointer update has landed
  task automatic checkPtr(input logic [3:0] e);
    @(negedge clock);
    check("calPointer", {12'h000, calPointer}, {12'h000, e});
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // whole run is under two hundred cycles
  initial
  begin
    repeat (4000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end

  initial
  begin
    n_mismatch = 0;
    checks_done = 0;
    rst_n = 1'b0;
    convBusy = 1'b0;
    calRunning = 1'b0;
    convResult = 12'h5A3;
    calEngWrite = 1'b0;
    calEngIndex = 4'h0;
    calEngData = 14'h0000;
    repeat (3) @(negedge clock);
    check("statusWord", statusWord, 16'h0000);
    check("calPointer", {12'h000, calPointer}, 16'h0000);
    rst_n = 1'b1;
    $display("test reset done");

    for (int k = 0; k < 3; k++)
    begin
      convBusy = BUSY_SET[k];
      calRunning = RUN_SET[k];
      i_host_model.writeCtrl(stWord[k]);
      i_host_model.readOne(w);
      check("status", w, expStatus(stWord[k], BUSY_SET[k], RUN_SET[k], stWord[k][5]));
      i_host_model.readOne(w);
      check("status reread", w, expStatus(stWord[k], BUSY_SET[k], RUN_SET[k], 1'b0));
      check("statusWord", statusWord, expStatus(stWord[k], BUSY_SET[k], RUN_SET[k], 1'b0));
    end
    convBusy = 1'b0;
    calRunning = 1'b0;
    $display("test status done");

    // writes only in this sequence, reads only in the next
    i_host_model.writeCtrl(16'h0080);
    checkPtr(4'h0);
    for (int k = 0; k < 10; k++)
    begin
      calVal[k] = 16'hC000 | (16'h0123 * 16'(k + 1));
      i_host_model.writeCal(calVal[k]);
      checkPtr((k == 9) ? 4'h0 : 4'(k + 1));
    end
    @(negedge clock);
    calEngWrite = 1'b1;
    calEngIndex = 4'h5;
    calEngData = 14'h2ABC;
    @(negedge clock);
    calEngWrite = 1'b0;
    calEngIndex = 4'hA;
    calVal[5] = 16'h2ABC;
    i_host_model.writeCtrl(16'h0080);
    for (int k = 0; k < 10; k++)
    begin
      i_host_model.readOne(w);
      check("cal read", w, {2'b00, calVal[k][13:0]});
    end
    checkPtr(4'h0);
    $display("test cal all done");

    for (int s = 1; s < 4; s++)
    begin
      i_host_model.writeCtrl(16'h0080 | 16'(s << 1));
      checkPtr((s == 2) ? 4'h1 : 4'h0);
      for (int k = 0; k < 3; k++)
      begin
        i_host_model.readOne(w);
        check("cal read sel", w, {2'b00, calVal[(s == 1) ? (k % 2) : ((s == 2) ? 1 : 0)][13:0]});
      end
    end
    $display("test cal select done");

    i_host_model.writeCtrl(16'h0080);
    repeat (3) i_host_model.readOne(w);
    checkPtr(4'h3);
    i_host_model.writeCtrl(16'h0080);
    checkPtr(4'h0);
    $display("test abandon done");

    i_host_model.writeCtrl(16'h0000);
    i_host_model.readOne(w);
    check("result read", w, 16'h05A3);
    i_host_model.writeCtrl(16'h0040);
    i_host_model.readOne(w);
    check("test read", w, 16'h0000);
    $display("test other selects done");

    // host write clashes with the engine and must be dropped
    i_host_model.writeCtrl(16'h0086);
    calEngWrite = 1'b1;
    calEngIndex = 4'h0;
    calEngData = 14'h1357;
    i_host_model.writeCal(16'h3FFF);
    calEngWrite = 1'b0;
    calEngIndex = 4'hA;
    checkPtr(4'h0);
    i_host_model.readOne(w);
    check("engine wins", w, 16'h1357);
    check("host waits", {15'h0000, hung}, 16'h0000);
    $display("test engine priority done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
